// File: hw/hppi_ctrl.v
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "hppi_consts.vh"

module hppi_ctrl #(
    parameter NPORT = 4
) (
    input wire clk_sys_i,
    input wire srst_i,
    input wire supply_source_strap_i,
    input wire upstream_bus_sense_i,
    output reg dplus_pullup_o,
    output reg eeprom_cs_o,
    output reg eeprom_sck_o,
    input wire eeprom_serial_io_i,
    output reg eeprom_serial_io_o,
    output reg eeprom_serial_io_oe_o,
    input wire [NPORT-1:0] overcurrent_in_n_i,
    output reg [NPORT-1:0] port_supply_switch_n_o,
    output reg [NPORT-1:0] port_supply_switch_n_oe_o,
    output reg [NPORT-1:0] green_lamp_n_o,
    output reg [NPORT-1:0] amber_lamp_n_o,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam S_START = 2'b00;
    localparam S_SHIFT = 2'b01;
    localparam S_DONE = 2'b10;
    localparam [15:0] EE_WORD = `HPPI_EE_READ_WORD;

    // Pin synchronisers; first stage read only by the second
    reg [1:0] strap_sync;
    reg [1:0] bus_sync;
    reg [1:0] io_sync;
    reg [NPORT-1:0] ovc_meta;
    reg [NPORT-1:0] ovc_sync;

    reg [1:0] state;
    reg [3:0] div_cnt;
    reg [4:0] bit_cnt;
    reg [15:0] tx_sr;
    reg [7:0] rx_sr;
    reg [7:0] cfg;
    reg cfg_done;

    reg [NPORT-1:0] pwr_en;
    reg [NPORT-1:0] green_on;
    reg [NPORT-1:0] amber_on;
    reg [NPORT-1:0] fault;

    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire ovc_pol = cfg[`HPPI_CFG_OVC_POL];
    wire led_pol = cfg[`HPPI_CFG_LED_POL];
    wire pwr_pol = cfg[`HPPI_CFG_PWR_POL];
    // Polarity unknown until the byte is in, so no fault before then
    wire [NPORT-1:0] ovc_act = (ovc_sync ^ {NPORT{~ovc_pol}})
        & {NPORT{cfg_done}};
    wire sck_tick = (div_cnt == `HPPI_SCK_HALF_CYC - 4'h1);
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (aw_addr == `HPPI_ADDR_CTRL) && w_strb[0];
    wire wr_ctrl1 = wr_go && (aw_addr == `HPPI_ADDR_CTRL) && w_strb[1];
    wire wr_fault = wr_go && (aw_addr == `HPPI_ADDR_FAULT) && w_strb[0];

    // Drive level for a pin group given its polarity bit
    function [NPORT-1:0] pin_level;
        input [NPORT-1:0] on;
        input pol;
        begin
            pin_level = on ^ {NPORT{~pol}};
        end
    endfunction

    function [31:0] status_word;
        input dummy;
        begin
            status_word = 32'h0000_0000;
            status_word[`HPPI_ST_STRAP] = strap_sync[1];
            status_word[`HPPI_ST_BUS] = bus_sync[1];
            status_word[`HPPI_ST_CFG_DONE] = cfg_done;
            status_word[`HPPI_ST_PULLUP] = dplus_pullup_o;
            status_word[`HPPI_ST_OVC_LSB +: NPORT] = ovc_act;
            status_word[`HPPI_ST_POL_LSB +: 3] = cfg[2:0];
        end
    endfunction

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            strap_sync <= 2'b00;
            bus_sync <= 2'b00;
            io_sync <= 2'b00;
            ovc_meta <= {NPORT{1'b1}};
            ovc_sync <= {NPORT{1'b1}};
            dplus_pullup_o <= 1'b0;
        end else begin
            strap_sync <= {strap_sync[0], supply_source_strap_i};
            bus_sync <= {bus_sync[0], upstream_bus_sense_i};
            io_sync <= {io_sync[0], eeprom_serial_io_i};
            ovc_meta <= overcurrent_in_n_i;
            ovc_sync <= ovc_meta;
            dplus_pullup_o <= bus_sync[1] && cfg_done;
        end
    end

    // Configuration read; SCK derived from the system clock
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= S_START;
            div_cnt <= 4'h0;
            bit_cnt <= 5'h00;
            tx_sr <= 16'h0000;
            rx_sr <= 8'h00;
            cfg <= `HPPI_CFG_RESET;
            cfg_done <= 1'b0;
            eeprom_cs_o <= 1'b0;
            eeprom_sck_o <= 1'b0;
            eeprom_serial_io_o <= 1'b0;
            eeprom_serial_io_oe_o <= 1'b0;
        end else begin
            case (state)
                S_START: begin
                    eeprom_cs_o <= 1'b1;
                    tx_sr <= {`HPPI_EE_READ_WORD} << 1;
                    eeprom_serial_io_o <= EE_WORD[15];
                    eeprom_serial_io_oe_o <= 1'b1;
                    div_cnt <= 4'h0;
                    bit_cnt <= 5'h00;
                    state <= S_SHIFT;
                end
                S_SHIFT: begin
                    div_cnt <= sck_tick ? 4'h0 : div_cnt + 4'h1;
                    if (sck_tick && !eeprom_sck_o) begin
                        eeprom_sck_o <= 1'b1;
                        if (bit_cnt >= `HPPI_EE_TX_BITS)
                            rx_sr <= {rx_sr[6:0], io_sync[1]};
                    end else if (sck_tick) begin
                        eeprom_sck_o <= 1'b0;
                        if (bit_cnt == `HPPI_EE_LAST_BIT) begin
                            eeprom_cs_o <= 1'b0;
                            cfg <= rx_sr;
                            cfg_done <= 1'b1;
                            state <= S_DONE;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                            eeprom_serial_io_o <= tx_sr[15];
                            tx_sr <= {tx_sr[14:0], 1'b0};
                            // Release the line once the address is out
                            eeprom_serial_io_oe_o <=
                                (bit_cnt + 5'h01) < `HPPI_EE_TX_BITS;
                        end
                    end
                end
                S_DONE: begin
                    eeprom_serial_io_oe_o <= 1'b0;
                end
                default: begin
                    state <= S_START;
                end
            endcase
        end
    end

    // Port control; the overcurrent cut beats a software enable
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            pwr_en <= {NPORT{1'b0}};
            green_on <= {NPORT{1'b0}};
            amber_on <= {NPORT{1'b0}};
            fault <= {NPORT{1'b0}};
            port_supply_switch_n_o <= {NPORT{1'b1}};
            port_supply_switch_n_oe_o <= {NPORT{1'b0}};
            green_lamp_n_o <= {NPORT{1'b1}};
            amber_lamp_n_o <= {NPORT{1'b1}};
        end else begin
            if (wr_ctrl) begin
                pwr_en <= w_data[`HPPI_CTRL_PWR_LSB +: NPORT] & ~ovc_act;
                green_on <= w_data[`HPPI_CTRL_GREEN_LSB +: NPORT];
            end else begin
                pwr_en <= pwr_en & ~ovc_act;
            end
            if (wr_ctrl1)
                amber_on <= w_data[`HPPI_CTRL_AMBER_LSB +: NPORT];
            if (wr_fault)
                fault <= (fault & ~w_data[NPORT-1:0]) | ovc_act;
            else
                fault <= fault | ovc_act;
            port_supply_switch_n_o <= pin_level(pwr_en, pwr_pol);
            // Stay floating until polarity is known
            port_supply_switch_n_oe_o <= {NPORT{cfg_done}};
            green_lamp_n_o <= pin_level(green_on, led_pol);
            amber_lamp_n_o <= pin_level(amber_on, led_pol);
        end
    end

    // AXI4-Lite slave: address and data taken in either order
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HPPI_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `HPPI_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == `HPPI_ADDR_CTRL ||
                    aw_addr == `HPPI_ADDR_FAULT) ? `HPPI_RESP_OKAY
                    : `HPPI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `HPPI_RESP_OKAY;
                case ({s_axi_araddr[3:2], 2'b00})
                    `HPPI_ADDR_CTRL: s_axi_rdata <=
                        ({{(32-NPORT){1'b0}}, amber_on} << `HPPI_CTRL_AMBER_LSB)
                        | ({{(32-NPORT){1'b0}}, green_on}
                        << `HPPI_CTRL_GREEN_LSB)
                        | {{(32-NPORT){1'b0}}, pwr_en};
                    `HPPI_ADDR_STATUS: s_axi_rdata <= status_word(1'b0);
                    `HPPI_ADDR_FAULT: s_axi_rdata <=
                        {{(32-NPORT){1'b0}}, fault};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `HPPI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // hppi_ctrl

// File: hw/hppi_consts.vh
`ifndef HPPI_CONSTS_VH
`define HPPI_CONSTS_VH

// Register byte addresses
`define HPPI_ADDR_CTRL 4'h0
`define HPPI_ADDR_STATUS 4'h4
`define HPPI_ADDR_FAULT 4'h8

// Control register fields
`define HPPI_CTRL_PWR_LSB 0
`define HPPI_CTRL_GREEN_LSB 4
`define HPPI_CTRL_AMBER_LSB 8
`define HPPI_CTRL_RESET 32'h0000_0000

// Status register fields
`define HPPI_ST_STRAP 0
`define HPPI_ST_BUS 1
`define HPPI_ST_CFG_DONE 2
`define HPPI_ST_PULLUP 3
`define HPPI_ST_OVC_LSB 4
`define HPPI_ST_POL_LSB 8

// Configuration byte: a set bit makes that pin group active high
`define HPPI_CFG_LED_POL 0
`define HPPI_CFG_OVC_POL 1
`define HPPI_CFG_PWR_POL 2
`define HPPI_CFG_RESET 8'h00

// Serial memory read: opcode and address sent as one 16-bit word
`define HPPI_EE_READ_WORD 16'h0300
`define HPPI_EE_TX_BITS 5'h10
`define HPPI_EE_LAST_BIT 5'h17
`define HPPI_SCK_HALF_CYC 4'h4

// Bus answers
`define HPPI_RESP_OKAY 2'b00
`define HPPI_RESP_SLVERR 2'b10

`endif

// File: test/hppi_eeprom_model.sv
`timescale 1ns/10ps
module hppi_eeprom_model (
    input wire cs_i,
    input wire sck_i,
    input wire line_i,
    input wire [7:0] cfg_i,
    output reg drv_o,
    output reg bit_o,
    output reg [15:0] cmd_o
);
    reg [4:0] cnt;
    initial begin
        {drv_o, bit_o, cnt, cmd_o} = 23'h0;
    end
    // Command shifts in on rising clock, MSB first
    always @(posedge sck_i or negedge cs_i) begin
        if (!cs_i) begin
            cnt <= 5'h00;
        end else begin
            if (cnt < 5'h10) cmd_o <= {cmd_o[14:0], line_i};
            cnt <= cnt + 5'h01;
        end
    end
    // Data changes on falling clock; released as soon as select drops
    always @(negedge sck_i or negedge cs_i) begin
        if (!cs_i) begin
            drv_o <= 1'b0;
        end else if (cnt >= 5'h10 && cnt < 5'h18) begin
            drv_o <= 1'b1;
            bit_o <= cfg_i[5'h17 - cnt];
        end
    end
endmodule // hppi_eeprom_model

// File: test/hppi_ctrl_properties.sv
`timescale 1ns/10ps
module hppi_ctrl_checker #(
    parameter NPORT = 4
) (
    input wire clk_sys_i,
    input wire srst_i,
    input wire upstream_bus_sense_i,
    input wire dplus_pullup_o,
    input wire eeprom_cs_o,
    input wire eeprom_sck_o,
    input wire eeprom_serial_io_i,
    input wire eeprom_serial_io_oe_o,
    input wire [NPORT-1:0] overcurrent_in_n_i,
    input wire [NPORT-1:0] port_supply_switch_n_o,
    input wire [NPORT-1:0] port_supply_switch_n_oe_o,
    input wire [NPORT-1:0] green_lamp_n_o,
    input wire [NPORT-1:0] amber_lamp_n_o
);
    reg sck_q;
    reg [4:0] nb;
    reg [7:0] cfg;
    wire [NPORT-1:0] oc_act = ~(overcurrent_in_n_i ^ {NPORT{cfg[1]}});
    wire [NPORT-1:0] pwr_on = port_supply_switch_n_oe_o &
        ~(port_supply_switch_n_o ^ {NPORT{cfg[2]}});
    // Polarity byte is not a port, so it is sniffed off the wire
    always @(posedge clk_sys_i) begin
        sck_q <= eeprom_sck_o;
        if (srst_i) cfg <= 8'h00;
        else if (eeprom_sck_o && !sck_q && nb >= 5'h10)
            cfg <= {cfg[6:0], eeprom_serial_io_i};
        if (srst_i || !eeprom_cs_o) nb <= 5'h00;
        else if (eeprom_sck_o && !sck_q) nb <= nb + 5'h01;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence s_bus_gone;
        !upstream_bus_sense_i [*4];
    endsequence
    sequence s_ovc_held;
        ($stable(oc_act) && oc_act != 0) [*4];
    endsequence
    a_pullup_bus_gate: assert property (
        s_bus_gone |-> ##1 !dplus_pullup_o)
        else $error("pull-up on without bus power");
    a_pullup_cfg_gate: assert property (dplus_pullup_o |->
        !eeprom_cs_o && &port_supply_switch_n_oe_o)
        else $error("pull-up on before config read");
    a_cs_sck_idle: assert property (
        !eeprom_cs_o |-> !eeprom_sck_o)
        else $error("serial clock moves while deselected");
    a_io_drive_window: assert property (
        eeprom_serial_io_oe_o |-> eeprom_cs_o)
        else $error("data line driven outside a frame");
    a_io_read_release: assert property (
        nb > 5'h10 |-> !eeprom_serial_io_oe_o)
        else $error("data line driven while reading");
    a_sck_half_period: assert property (
        $rose(eeprom_sck_o) |-> eeprom_sck_o [*4])
        else $error("serial clock high phase too short");
    a_ovc_power_off: assert property (
        s_ovc_held |-> ##1 (oc_act & pwr_on) == 0)
        else $error("power left on during overcurrent");
    a_lamps_idle_reset: assert property ($fell(srst_i) |->
        &green_lamp_n_o && &amber_lamp_n_o)
        else $error("lamps not idle high after reset");
    a_switch_float_reset: assert property (
        $fell(srst_i) |->
        port_supply_switch_n_oe_o == 0 && !dplus_pullup_o)
        else $error("switch driven after reset");
endmodule // hppi_ctrl_checker
bind hppi_ctrl hppi_ctrl_checker #(.NPORT(NPORT)) u_chk (.*);

// File: test/hppi_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "hppi_consts.vh"
module hppi_ctrl_tb_top;
    logic clk_sys_i, srst_i, supply_source_strap_i, upstream_bus_sense_i;
    logic [3:0] overcurrent_in_n_i, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    wire dplus_pullup_o, eeprom_cs_o, eeprom_sck_o, eeprom_serial_io_o;
    wire eeprom_serial_io_oe_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, ee_drv, ee_bit, eeprom_serial_io_i;
    wire [3:0] port_supply_switch_n_o, port_supply_switch_n_oe_o;
    wire [3:0] green_lamp_n_o, amber_lamp_n_o;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] ee_cmd;
    logic [7:0] cfg;
    int err_count, tests_run;
    // Pull-down on the line: a released line reads low
    assign eeprom_serial_io_i = eeprom_serial_io_oe_o ? eeprom_serial_io_o :
        ee_drv & ee_bit;
    hppi_ctrl dut (.*);
    hppi_eeprom_model u_ee (.cs_i(eeprom_cs_o), .sck_i(eeprom_sck_o),
        .line_i(eeprom_serial_io_i), .cfg_i(cfg), .drv_o(ee_drv),
        .bit_o(ee_bit), .cmd_o(ee_cmd));
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function [3:0] lv(input [3:0] on, input p);
        lv = p ? on : ~on;
    endfunction
    task wr(input [3:0] a, input [31:0] d, output [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task rd(input [3:0] a, output [31:0] d, output [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task t_boot(input [7:0] c, input s);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        cfg = c;
        {srst_i, supply_source_strap_i, upstream_bus_sense_i} <= {1'b1, s, 1'b1};
        overcurrent_in_n_i <= {4{~c[1]}};
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({green_lamp_n_o, amber_lamp_n_o, port_supply_switch_n_oe_o,
            dplus_pullup_o}, 32'h1fe0);
        n = 0;
        do begin
            rd(`HPPI_ADDR_STATUS, d, r);
            n++;
        end while (d[2] !== 1'b1 && n < 100);
        // Pull-up trails config done by a cycle
        rd(`HPPI_ADDR_STATUS, d, r);
        chk(d, {21'h0, c[2:0], 7'h07, s});
        chk(ee_cmd, `HPPI_EE_READ_WORD);
    endtask
    task t_ctrl(input [7:0] c);
        logic [31:0] d;
        logic [1:0] r;
        wr(`HPPI_ADDR_CTRL, 32'h0a5f, r);
        chk(r, `HPPI_RESP_OKAY);
        repeat (3) @(posedge clk_sys_i);
        chk({port_supply_switch_n_oe_o, port_supply_switch_n_o, green_lamp_n_o,
            amber_lamp_n_o}, {4'hf, lv(4'hf, c[2]), lv(4'h5, c[0]),
            lv(4'ha, c[0])});
        wr(4'hc, 32'h1, r);
        chk(r, `HPPI_RESP_SLVERR);
        rd(4'hc, d, r);
        chk(d, 32'h0);
        chk(r, `HPPI_RESP_SLVERR);
    endtask
    task t_ovc(input [7:0] c);
        logic [31:0] d;
        logic [1:0] r;
        overcurrent_in_n_i <= {4{~c[1]}} ^ 4'h4;
        repeat (6) @(posedge clk_sys_i);
        chk({port_supply_switch_n_oe_o, port_supply_switch_n_o},
            {4'hf, lv(4'hb, c[2])});
        rd(`HPPI_ADDR_FAULT, d, r);
        chk(d, 32'h4);
        rd(`HPPI_ADDR_STATUS, d, r);
        chk(d[7:4], 4'h4);
        overcurrent_in_n_i <= {4{~c[1]}};
        repeat (6) @(posedge clk_sys_i);
        wr(`HPPI_ADDR_FAULT, 32'h4, r);
        rd(`HPPI_ADDR_FAULT, d, r);
        chk(d, 32'h0);
        rd(`HPPI_ADDR_CTRL, d, r);
        chk(d, 32'h0a5b);
    endtask
    task t_bus(input s);
        logic [31:0] d;
        logic [1:0] r;
        upstream_bus_sense_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk(dplus_pullup_o, 32'h0);
        rd(`HPPI_ADDR_STATUS, d, r);
        chk(d[3:0], {3'b010, s});
    endtask
    initial begin
        {srst_i, supply_source_strap_i, upstream_bus_sense_i} = 3'b100;
        {overcurrent_in_n_i, s_axi_awaddr, s_axi_araddr} = 12'hf00;
        {s_axi_wdata, s_axi_wstrb, cfg} = 44'h00f00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready, err_count, tests_run} = 66'h0;
        // Second pass flips every polarity and the strap
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys_i);
            t_boot(p ? 8'h07 : 8'h00, p[0]);
            t_ctrl(p ? 8'h07 : 8'h00);
            t_ovc(p ? 8'h07 : 8'h00);
            t_bus(p[0]);
        end
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        complete_run;
    end
endmodule // hppi_ctrl_tb_top
